/* include/fcs_defs.svh */
// constants of the flash command sequencer: register offsets, fields, limits
// assumes a 32-bit Avalon-MM word bus; offsets are word addresses
// Summary of operation
// R1 - only security pattern 10 means unsecured
// R2 - parameter index bits RW, rest read zero
// R3 - parameter index selects accessed array word
// R4 - ECC index selects report word, RW bits
// R5 - writing one to complete flag launches
// R6 - flag low while busy, set on completion
// R7 - read-once needs index 001 at launch
// R8 - read-once errors: load active, mode, phrase
// R9 - read-once verify bits from read errors
// R10 - load-data words: code 05, address, data
// R11 - load-data phrase address low bits zero
// R12 - load-data parameters kept, flag then sets
// R13 - other command or error cancels load
// R14 - query needs index 000, no load, mode
// R15 - partition words: code 20, two counts
// R16 - partition counts at most 128 and 16
// R17 - remaining at least 12, ratio at least 8; code checks both only when the emulation sector count is nonzero
// R18 - erase-verify then program info register
// R19 - software erases all blocks before partition
// R20 - software loads every parameter word first
// R21 - failed partition aborts with access error
`ifndef FCS_DEFS_SVH
`define FCS_DEFS_SVH
`define FCS_OFF_STAT 4'h0
`define FCS_OFF_PIDX 4'h1
`define FCS_OFF_PARAM 4'h2
`define FCS_OFF_EIDX 4'h3
`define FCS_OFF_ECC 4'h4
`define FCS_OFF_SEC 4'h5
`define FCS_OFF_MODE 4'h6
`define FCS_ST_COMMAND_COMPLETE_FLAG 7
`define FCS_ST_ACC 5
`define FCS_ST_PV 4
`define FCS_ST_MG1 1
`define FCS_ST_MG0 0
`define FCS_SEC_UNSEC 2'h2
`define FCS_SEC_RESET 2'h1
`define FCS_CMD_READONCE 8'h04
`define FCS_CMD_PROGP 8'h06
`define FCS_CMD_LOAD 8'h05
`define FCS_CMD_QUERY 8'h15
`define FCS_CMD_PART 8'h20
`define FCS_DF_SECTORS 8'h80
`define FCS_ER_MAX 8'h10
`define FCS_MIN_REMAIN 8'h0C
`define FCS_MIN_RATIO 8'h08
`define FCS_INFO_ADDR 23'h120000
`define FCS_EXEC_CYCLES 4'h4
`endif

/* include/fcs_pkg.sv */
// types of the flash command sequencer
// assumes fcs_defs.svh for numeric constants
package fcs_pkg;
    typedef enum {FCS_IDLE, FCS_EXEC, FCS_ERASE, FCS_PROG, FCS_DONE} fcs_state_t;
    typedef struct packed {
        logic req;
        logic [7:0] cmd;
        logic [22:0] addr;
        logic [15:0] data;
    } fcs_mc_req_t;
    typedef struct packed {
        logic done;
        logic readErr;
        logic uncorrErr;
        logic fail;
    } fcs_mc_rsp_t;
endpackage : fcs_pkg

/* design/fcs_sequencer.sv */
// flash command sequencer: parameter array, launch handshake, error checks
// assumes a memory controller that answers each request with one done pulse
`include "fcs_defs.svh"
module fcs_sequencer #(
    parameter int PARAM_WORDS = 8,
    parameter int ECC_WORDS = 8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [3:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWriteData,
    input wire logic [3:0] avsByteEnable,
    output logic [31:0] avsReadData,
    output logic avsWaitRequest,
    input wire logic [15:0] eccReportIn [ECC_WORDS],
    output fcs_pkg::fcs_mc_req_t mcReq,
    input fcs_pkg::fcs_mc_rsp_t mcRsp,
    output logic unsecured,
    output logic loadActive
);
    import fcs_pkg::*;

    // index registers are three bits wide, so both arrays must hold eight words
    if (PARAM_WORDS != 8 || ECC_WORDS != 8)
    begin : g_bad_size
        $error("fcs_sequencer: index fields are three bits wide");
    end

    logic [15:0] param_r [PARAM_WORDS];
    logic [2:0] pIdx_r;
    logic [2:0] eIdx_r;
    logic [1:0] sec_r;
    logic modeOk_r;
    logic command_complete_flag_r;
    logic access_error_flag_r;
    logic pViol_r;
    logic mg1_r;
    logic mg0_r;
    logic load_r;
    logic rdAck_r;
    logic [31:0] rdData_r;
    fcs_state_t state_r;
    fcs_mc_req_t mcReq_r;

    wire wrStb = avsWrite & ~avsRead & avsByteEnable[0];
    wire wrStat = wrStb && avsAddress == `FCS_OFF_STAT;
    wire wrPIdx = wrStb && avsAddress == `FCS_OFF_PIDX;
    wire wrParam = wrStb && avsAddress == `FCS_OFF_PARAM && command_complete_flag_r;
    wire wrEIdx = wrStb && avsAddress == `FCS_OFF_EIDX;
    wire wrSec = wrStb && avsAddress == `FCS_OFF_SEC;
    wire wrMode = wrStb && avsAddress == `FCS_OFF_MODE;
    // R5 launch by write one
    wire launch = wrStat && avsWriteData[`FCS_ST_COMMAND_COMPLETE_FLAG] && command_complete_flag_r;
    wire clrAcc = wrStat && avsWriteData[`FCS_ST_ACC];
    wire clrPv = wrStat && avsWriteData[`FCS_ST_PV];
    wire [7:0] cmd = param_r[0][15:8];
    wire [7:0] user_partition_sectors = param_r[1][7:0];
    wire [7:0] buffer_ram_emulation_sectors = param_r[2][7:0];
    wire [7:0] remain = `FCS_DF_SECTORS - user_partition_sectors;
    // R11 phrase address low bits
    wire phraseBad = param_r[1][2:0] != 3'h0;
    // R7 R8 read-once checks
    wire roErr = pIdx_r != 3'h1 || load_r || !modeOk_r || phraseBad;
    // R14 query checks
    wire qErr = pIdx_r != 3'h0 || load_r || !modeOk_r;
    // R16 R17 partition validation
    wire partBad = user_partition_sectors > `FCS_DF_SECTORS || buffer_ram_emulation_sectors > `FCS_ER_MAX ||
        (buffer_ram_emulation_sectors != 8'h0 && (remain < `FCS_MIN_REMAIN ||
        {4'h0, remain} < ({4'h0, buffer_ram_emulation_sectors} * 12'(`FCS_MIN_RATIO))));
    wire loadErr = phraseBad || pIdx_r != 3'h5;
    wire launchErr = (cmd == `FCS_CMD_READONCE && roErr) ||
        (cmd == `FCS_CMD_QUERY && qErr) ||
        (cmd == `FCS_CMD_PART && partBad) ||
        (cmd == `FCS_CMD_LOAD && loadErr);

    // R1 security decode
    assign unsecured = sec_r == `FCS_SEC_UNSEC;
    assign loadActive = load_r;
    assign mcReq = mcReq_r;
    assign avsReadData = rdData_r;
    assign avsWaitRequest = avsRead & ~rdAck_r;

    logic [31:0] rdMux;
    always_comb
    begin
        rdMux = 32'h0;
        case (avsAddress)
            `FCS_OFF_STAT: rdMux = {24'h0, command_complete_flag_r, 1'b0, access_error_flag_r, pViol_r, 2'h0, mg1_r, mg0_r};
            // R2 unused index bits zero
            `FCS_OFF_PIDX: rdMux = {29'h0, pIdx_r};
            // R3 indexed array read
            `FCS_OFF_PARAM: rdMux = {16'h0, param_r[pIdx_r]};
            `FCS_OFF_EIDX: rdMux = {29'h0, eIdx_r};
            // R4 ECC report select
            `FCS_OFF_ECC: rdMux = {16'h0, eccReportIn[eIdx_r]};
            `FCS_OFF_SEC: rdMux = {30'h0, sec_r};
            `FCS_OFF_MODE: rdMux = {31'h0, modeOk_r};
            default: rdMux = 32'h0;
        endcase
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            rdAck_r <= 1'b0;
            rdData_r <= 32'h0;
        end
        else
        begin
            rdAck_r <= avsRead & ~rdAck_r;
            rdData_r <= (avsRead & ~rdAck_r) ? rdMux : rdData_r;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            pIdx_r <= 3'h0;
            eIdx_r <= 3'h0;
            sec_r <= `FCS_SEC_RESET;
            modeOk_r <= 1'b1;
        end
        else
        begin
            if (wrPIdx)
                pIdx_r <= avsWriteData[2:0];
            if (wrEIdx)
                eIdx_r <= avsWriteData[2:0];
            if (wrSec)
                sec_r <= avsWriteData[1:0];
            if (wrMode)
                modeOk_r <= avsWriteData[0];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < PARAM_WORDS; gi++)
        begin : g_param
            // R3 indexed array write
            always_ff @(posedge clock or posedge rst)
            begin
                if (rst)
                    param_r[gi] <= 16'h0;
                else if (wrParam && pIdx_r == 3'(gi))
                    param_r[gi] <= avsWriteData[15:0];
            end
        end
    endgenerate

    wire mcDone = mcRsp.done;
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state_r <= FCS_IDLE;
            command_complete_flag_r <= 1'b1;
            access_error_flag_r <= 1'b0;
            pViol_r <= 1'b0;
            mg1_r <= 1'b0;
            mg0_r <= 1'b0;
            load_r <= 1'b0;
            mcReq_r <= '0;
        end
        else
        begin
            mcReq_r.req <= 1'b0;
            if (clrAcc)
                access_error_flag_r <= 1'b0;
            if (clrPv)
                pViol_r <= 1'b0;
            case (state_r)
                FCS_IDLE:
                begin
                    if (launch)
                    begin
                        command_complete_flag_r <= 1'b0;
                        mg1_r <= 1'b0;
                        mg0_r <= 1'b0;
                        // R13 cancel on other command
                        if (cmd != `FCS_CMD_LOAD && cmd != `FCS_CMD_PROGP)
                            load_r <= 1'b0;
                        if (launchErr)
                        begin
                            // R21 abort with access error
                            access_error_flag_r <= 1'b1;
                            // R13 cancel on error
                            load_r <= 1'b0;
                            state_r <= FCS_DONE;
                        end
                        else
                        begin
                            mcReq_r <= '{1'b1, cmd, {param_r[0][6:0], param_r[1]}, param_r[2]};
                            state_r <= cmd == `FCS_CMD_PART ? FCS_ERASE : FCS_EXEC;
                        end
                    end
                end
                FCS_EXEC:
                begin
                    // R9 read-once verify bits
                    if (mcDone && cmd == `FCS_CMD_READONCE)
                    begin
                        mg1_r <= mcRsp.readErr;
                        mg0_r <= mcRsp.uncorrErr;
                    end
                    if (mcDone)
                    begin
                        // R12 keep load parameters
                        if (cmd == `FCS_CMD_LOAD)
                            load_r <= ~mcRsp.fail;
                        if (cmd == `FCS_CMD_PROGP || mcRsp.fail)
                            load_r <= 1'b0;
                        if (mcRsp.fail)
                            access_error_flag_r <= 1'b1;
                        state_r <= FCS_DONE;
                    end
                end
                FCS_ERASE:
                begin
                    // R18 erase-verify first
                    if (mcDone)
                    begin
                        if (mcRsp.fail)
                        begin
                            access_error_flag_r <= 1'b1;
                            state_r <= FCS_DONE;
                        end
                        else
                        begin
                            mcReq_r <= '{1'b1, `FCS_CMD_PART, `FCS_INFO_ADDR, {8'h0, user_partition_sectors}};
                            state_r <= FCS_PROG;
                        end
                    end
                end
                FCS_PROG:
                begin
                    // R18 program info register
                    if (mcDone)
                    begin
                        if (mcRsp.fail)
                            access_error_flag_r <= 1'b1;
                        state_r <= FCS_DONE;
                    end
                end
                FCS_DONE:
                begin
                    // R6 set flag on completion
                    command_complete_flag_r <= 1'b1;
                    state_r <= FCS_IDLE;
                end
                default: state_r <= FCS_IDLE;
            endcase
        end
    end

    // R6 flag low while executing
    flag_busy_a: assert property (@(posedge clock) disable iff (rst)
        state_r != FCS_IDLE |-> !command_complete_flag_r)
        else $error("complete flag high while busy");
    launch_clears_a: assert property (@(posedge clock) disable iff (rst) // R5
        launch |=> !command_complete_flag_r)
        else $error("launch did not clear complete flag");
    readonce_idx_a: assert property (@(posedge clock) disable iff (rst) // R7
        launch && cmd == `FCS_CMD_READONCE && pIdx_r != 3'h1 |=> access_error_flag_r)
        else $error("read once bad index not flagged");
    readonce_load_a: assert property (@(posedge clock) disable iff (rst) // R8
        launch && cmd == `FCS_CMD_READONCE && load_r |=> access_error_flag_r)
        else $error("read once during load not flagged");
    query_err_a: assert property (@(posedge clock) disable iff (rst) // R14
        launch && cmd == `FCS_CMD_QUERY && pIdx_r != 3'h0 |=> access_error_flag_r ##1 command_complete_flag_r)
        else $error("query bad index not flagged");
    part_abort_a: assert property (@(posedge clock) disable iff (rst) // R21
        launch && cmd == `FCS_CMD_PART && partBad |=> !mcReq_r.req ##1 command_complete_flag_r)
        else $error("bad partition not aborted");
    load_cancel_a: assert property (@(posedge clock) disable iff (rst) // R13
        launch && cmd != `FCS_CMD_LOAD && cmd != `FCS_CMD_PROGP |=> !load_r)
        else $error("load sequence not cancelled");
    sec_decode_a: assert property (@(posedge clock) disable iff (rst) // R1
        wrSec |=> unsecured == ($past(avsWriteData[1:0]) == 2'h2))
        else $error("security decode wrong");
    pidx_upper_a: assert property (@(posedge clock) disable iff (rst) // R2
        rdAck_r && $past(avsAddress) == `FCS_OFF_PIDX |-> avsReadData[31:3] == 29'h0)
        else $error("index upper bits not zero");
    info_addr_a: assert property (@(posedge clock) disable iff (rst) // R18
        state_r == FCS_ERASE && mcDone && !mcRsp.fail |=> mcReq_r.addr == `FCS_INFO_ADDR)
        else $error("info register address wrong");
    readonce_mg_a: assert property (@(posedge clock) disable iff (rst) // R9
        state_r == FCS_EXEC && mcDone && cmd == `FCS_CMD_READONCE |=>
        mg1_r == $past(mcRsp.readErr) && mg0_r == $past(mcRsp.uncorrErr))
        else $error("read once verify bits wrong");
    load_keep_a: assert property (@(posedge clock) disable iff (rst) // R12
        state_r == FCS_EXEC && mcDone && cmd == `FCS_CMD_LOAD && !mcRsp.fail |=> load_r)
        else $error("load sequence not kept");
    cov_launch_c: cover property (@(posedge clock) disable iff (rst) launch ##[1:20] command_complete_flag_r);
    cov_part_c: cover property (@(posedge clock) disable iff (rst) state_r == FCS_PROG);
    cov_load_c: cover property (@(posedge clock) disable iff (rst) $rose(load_r));
    cov_err_c: cover property (@(posedge clock) disable iff (rst) $rose(access_error_flag_r));
endmodule : fcs_sequencer

/* testbench/fcs_testbench.sv */
// bench for the flash command sequencer: bus tasks, memory controller stand-in
// assumes the sequencer answers each launch within a few dozen cycles
`include "fcs_defs.svh"
module testbench;
timeunit 1ns;
timeprecision 100ps;
import fcs_pkg::*;
// erase-all code is the bench's own pick; the sequencer passes it through unchecked
localparam logic [7:0] CMD_ERASE_ALL = 8'h08;
logic clock, rst, avsRead, avsWrite, avsWaitRequest, unsecured, loadActive, rdErr, ucErr;
logic failRsp;
logic [3:0] avsAddress, avsByteEnable;
logic [31:0] avsWriteData, avsReadData, q;
logic [15:0] ecc [8];
logic [15:0] w [8];
logic [15:0] pw [8];
logic [22:0] lastAddr;
logic [15:0] lastData;
fcs_mc_req_t mcReq;
fcs_mc_rsp_t mcRsp;
fcs_mc_req_t expQ [$];
fcs_mc_req_t expReq;
int bad_count, check_count, reqs, waitN, seed, df, er;
int dfList [9] = '{128, 129, 100, 117, 112, 113, 0, 116, 3};
int erList [9] = '{0, 0, 17, 1, 2, 2, 16, 1, 16};
fcs_sequencer i_dut (.clock(clock), .rst(rst), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .eccReportIn(ecc),
    .mcReq(mcReq), .mcRsp(mcRsp), .unsecured(unsecured), .loadActive(loadActive));
initial
begin
    clock = 0;
    forever #12.5 clock = ~clock;
end
function automatic int xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
endfunction : xorshift
// controller stand-in answers after a random 3 to 6 cycles
always @(posedge clock or posedge rst)
    if (rst)
    begin
        mcRsp <= '0;
        waitN <= 0;
        reqs <= 0;
    end
    else
    begin
        mcRsp <= '0;
        if (mcReq.req === 1'b1)
        begin
            reqs <= reqs + 1;
            lastAddr <= mcReq.addr;
            lastData <= mcReq.data;
            waitN <= 3 + (xorshift() & 3);
            if (expQ.size() == 0)
                chk("unexpected request", 0, 1);
            else
            begin
                expReq = expQ.pop_front();
                chk("request cmd", {24'h0, expReq.cmd}, {24'h0, mcReq.cmd});
                chk("request addr", {9'h0, expReq.addr}, {9'h0, mcReq.addr});
                chk("request data", {16'h0, expReq.data}, {16'h0, mcReq.data});
            end
        end
        else if (waitN > 0)
        begin
            waitN <= waitN - 1;
            if (waitN == 1)
                mcRsp <= {1'b1, rdErr, ucErr, failRsp};
        end
    end
task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
        $display("Testbench passed");
    else
        $display("Testbench failed");
    $finish;
endtask : wrap_up
task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
        $display("Error %s expected %h seen %h", nm, e, g);
        bad_count++;
    end
endtask : chk
task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avsAddress <= a;
    avsRead <= rd;
    avsWrite <= !rd;
    avsWriteData <= d;
    do
    begin
        @(posedge clock);
        n++;
    end
    while (avsWaitRequest !== 1'b0 && n < 40);
    q = avsReadData;
    if (n >= 40)
    begin
        bad_count++;
        wrap_up();
    end
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    @(posedge clock);
endtask : bus
task automatic rc(input string nm, input logic [3:0] a, input logic [31:0] m,
    input logic [31:0] e);
    bus(1'b1, a, 32'h0);
    chk(nm, e, q & m);
endtask : rc
task automatic setp(input int i, input logic [15:0] v);
    pw[i] = v;
    bus(1'b0, `FCS_OFF_PIDX, 32'(i));
    bus(1'b0, `FCS_OFF_PARAM, {16'h0, v});
endtask : setp
// nreq below zero: request count not checked
task automatic launch(input int idx, input logic acc, input int nreq);
    int n, r0;
    logic sawLow;
    bus(1'b0, `FCS_OFF_PIDX, 32'(idx));
    r0 = reqs;
    if (nreq > 0)
        expQ.push_back(fcs_mc_req_t'{1'b1, pw[0][15:8], {pw[0][6:0], pw[1]}, pw[2]});
    if (nreq == 2)
        expQ.push_back(fcs_mc_req_t'{1'b1, `FCS_CMD_PART, `FCS_INFO_ADDR, pw[1]});
    bus(1'b0, `FCS_OFF_STAT, 32'h80);
    sawLow = 1'b0;
    n = 0;
    do
    begin
        bus(1'b1, `FCS_OFF_STAT, 32'h0);
        sawLow |= (q[7] === 1'b0);
        n++;
    end
    while (q[7] !== 1'b1 && n < 40);
    if (n >= 40)
    begin
        bad_count++;
        wrap_up();
    end
    if (nreq > 0)
        chk("busy seen", 1, sawLow);
    if (nreq >= 0)
        chk("requests", nreq, reqs - r0);
    chk("access error", acc, q[5]);
    bus(1'b0, `FCS_OFF_STAT, 32'h20);
endtask : launch
task automatic load();
    setp(0, 16'h0501);
    setp(1, 16'h2340);
    for (int i = 2; i < 6; i++)
        setp(i, 16'(xorshift()));
    launch(5, 1'b0, 1);
    chk("load active", 1, loadActive);
endtask : load
initial
begin
    rst = 1'b1;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsAddress = 4'h0;
    avsWriteData = 32'h0;
    avsByteEnable = 4'hF;
    rdErr = 1'b0;
    ucErr = 1'b0;
    failRsp = 1'b0;
    seed = 30;
    foreach (ecc[i])
        ecc[i] = 16'(xorshift());
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk("unsecured", 0, unsecured);
    chk("load active", 0, loadActive);
    rc("security", `FCS_OFF_SEC, 32'h3, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
        bus(1'b0, `FCS_OFF_SEC, 32'(i ^ (i >> 1)));
        chk("unsecured", (i ^ (i >> 1)) == 2, unsecured);
    end
    bus(1'b0, `FCS_OFF_PIDX, 32'hFFFFFFFF);
    rc("param index", `FCS_OFF_PIDX, 32'hFFFFFFFF, 32'h7);
    bus(1'b0, `FCS_OFF_EIDX, 32'hFFFFFFFF);
    rc("ecc index", `FCS_OFF_EIDX, 32'hFFFFFFFF, 32'h7);
    rc("ecc word", `FCS_OFF_ECC, 32'hFFFF, {16'h0, ecc[7]});
    for (int i = 0; i < 8; i++)
    begin
        w[i] = 16'(xorshift());
        setp(i, w[i]);
    end
    for (int i = 7; i >= 0; i--)
    begin
        bus(1'b0, `FCS_OFF_PIDX, 32'(i));
        rc("param word", `FCS_OFF_PARAM, 32'hFFFF, {16'h0, w[i]});
    end
    setp(0, 16'h0400);
    setp(1, 16'h0000);
    launch(0, 1'b1, 0);
    for (int k = 0; k < 3; k++)
    begin
        rdErr <= k > 0;
        ucErr <= k == 2;
        launch(1, 1'b0, 1);
        rc("verify bits", `FCS_OFF_STAT, 32'h3, {30'h0, rdErr, ucErr});
    end
    rdErr <= 1'b0;
    ucErr <= 1'b0;
    bus(1'b0, `FCS_OFF_MODE, 32'h0);
    launch(1, 1'b1, 0);
    setp(0, 16'h1500);
    launch(0, 1'b1, 0);
    bus(1'b0, `FCS_OFF_MODE, 32'h1);
    launch(1, 1'b1, 0);
    for (int k = 0; k < 2; k++)
    begin
        load();
        setp(0, k ? 16'h1500 : 16'h0400);
        launch(k ? 0 : 1, 1'b1, 0);
        chk("load cancelled", 0, loadActive);
    end
    // a program that fails in the controller must drop the pending load
    load();
    failRsp <= 1'b1;
    setp(0, 16'h0600);
    launch(0, 1'b1, 1);
    chk("load cancelled", 0, loadActive);
    failRsp <= 1'b0;
    setp(0, {CMD_ERASE_ALL, 8'h00});
    launch(0, 1'b0, 1);
    for (int k = 0; k < 13; k++)
    begin
        df = k < 9 ? dfList[k] : xorshift() & 255;
        er = k < 9 ? erList[k] : xorshift() & 31;
        setp(0, 16'h2000);
        setp(1, 16'(df));
        setp(2, 16'(er));
        if (df <= 128 && er <= 16 && (er == 0 || (128 - df >= 12 && (128 - df) / er >= 8)))
        begin
            launch(2, 1'b0, 2);
            chk("info address", `FCS_INFO_ADDR, {9'h0, lastAddr});
            chk("info data", df, {16'h0, lastData});
        end
        else
            launch(2, 1'b1, 0);
    end
    chk("requests left", 0, expQ.size());
    wrap_up();
end
endmodule : testbench
